/* hdl/nmc_noise_mute.sv */
/*
 * nmc_noise_mute: fade management and receive noise suppression.
 * Noise triggers from the DSP ratio detector, the jitter integrator and
 * the zero-nibble detector drive a stepped mute ladder and a shared
 * interrupt; also holds receive PLL recovery controls.
 * Assumes all inputs synchronous to clock; Avalon-MM slave, one wait state.
 */
// Our own choices: register access over Avalon-MM and the register addresses.
// Behaviour
// - codec normal and suppress enable set: noise mutes receive voice at once
// - trigger-source field picks DSP noise or jitter triggers for muting
// - mute-sequence field sets number and size of attenuation steps
// - each trigger deepens muting 0,-6,-12,-18 dB, full, up to sequence max
// - mute length counter restarts per trigger; at endpoint one step removed
// - trigger during recovery raises muting again and restarts the counter
// - jitter and noise share one interrupt bit with separate status bits
// - DSP detector triggers when prediction-to-error ratio is below threshold
// - DSP triggers have enable bit, status bit, and raise shared interrupt
// - phase threshold in degrees decides which transitions count as jitter
// - enough significant jitter events in a frame produce a jitter trigger
// - jitter trigger sets its status and raises shared interrupt if enabled
// - all-zero nibble triggers muting, sets its status, raises interrupt
// - zero-nibble detection only in first multiplex mode with enable set
// - clearing timing recovery fixes sampling; indicators keep running
// - forced slow response limits PLL to about 108 ns per bit period
// - without slow force the PLL may return to fast acquisition on jitter
// - all link quality indicators except signal strength are interrupts
`timescale 1ns/1ns
`default_nettype none
module nmc_noise_mute
	import nmc_pkg::*;
#(
	parameter int FRAME_TICK_CYC = NMC_FRAME_TICK_CYC
)(
	input  wire logic              clock,           // system clock
	input  wire logic              rst_n,           // async reset, low
	input  wire logic [3:0]        avs_address,     // word address
	input  wire logic              avs_read,        // read request
	input  wire logic              avs_write,       // write request
	input  wire logic [31:0]       avs_writedata,   // write data
	input  wire logic [3:0]        avs_byteenable,  // byte lanes
	output logic [31:0]            avs_readdata,    // read data
	output logic                   avs_waitrequest, // stall
	output logic                   irq,             // level interrupt
	input  wire logic              predValid,       // ratio inputs valid
	input  wire logic [15:0]       predMag,         // predicted magnitude
	input  wire logic [15:0]       errMag,          // prediction error
	input  wire logic              rxEdge,          // rx data transition
	input  wire logic [7:0]        rxPhaseDeg,      // deviation, degrees
	input  wire logic              frameStart,      // frame boundary
	input  wire logic              nibbleValid,     // adpcm nibble strobe
	input  wire logic [3:0]        adpcmNibble,     // received nibble
	input  wire logic              dChanErr,        // d channel check fail
	input  wire logic              syncErr,         // sync check fail
	input  wire logic signed [15:0] rxSample,       // decoded sample
	input  wire logic              rxSampleValid,   // sample strobe
	output logic signed [15:0]     dacSample,       // to d/a path
	output logic                   dacValid,        // d/a strobe
	output logic                   timingRecoveryEn,// pll recovery on
	output logic                   pllSlowForce,    // slow response
	output logic [7:0]             pllMaxStepCyc,   // phase step limit
	output logic                   pllFastReq       // re-acquire pulse
);
	////////////////////////////////////////////////////////////////////
	logic [7:0]  dspCtl;
	nmc_nsctl_t  nsCtl;
	logic [7:0]  ratioThr;
	nmc_jitctl_t jitCtl;
	logic [7:0]  muteLen;
	logic [7:0]  intStat;
	logic [7:0]  intEn;
	logic [2:0]  receive_attenuation_reg;
	logic [1:0]  tmgCtl;
	logic [7:0]  devCfg;
	logic [2:0]  muteStep;
	logic [7:0]  lenCnt;
	nmc_phase_t  phase;
	logic [7:0]  jitCnt;
	logic        jitFired;
	logic [15:0] divCnt;
	logic        muteTick;
	logic [2:0]  muteLevel;
	logic [31:0] rdMux;
	logic [7:0]  byteAdr;
	logic        wrStb;
	logic        suppOn;
	logic        dspTrig;
	logic        jitTrig;
	logic        zeroTrig;
	logic        jitSig;
	logic        ladderTrig;
	logic [2:0]  maxStep;
	logic [2:0]  next_step;
	logic [23:0] ratioProd;

	assign byteAdr = {2'h0, avs_address, 2'h0};
	assign wrStb   = avs_write && !avs_waitrequest;

	////////////////////////////////////////////////////////////////////
	// bus slave: one wait state, access completes while waitrequest low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	always_comb begin
		rdMux = 32'h0;
		case (byteAdr)
			NMC_DSPCTL_ADR: rdMux[7:0]  = dspCtl;
			NMC_NSCTL_ADR:  rdMux[7:0]  = nsCtl;
			NMC_RATIO_ADR:  rdMux[7:0]  = ratioThr;
			NMC_JITCTL_ADR: rdMux[15:0] = jitCtl;
			NMC_MUTLEN_ADR: rdMux[7:0]  = muteLen;
			NMC_INTSRC_ADR: rdMux[7:0]  = intStat;
			NMC_INTMSK_ADR: rdMux[7:0]  = intEn;
			NMC_RXATT_ADR:  rdMux[2:0]  = receive_attenuation_reg;
			NMC_TMGCTL_ADR: rdMux[1:0]  = tmgCtl;
			NMC_DEVCFG_ADR: rdMux[7:0]  = devCfg;
			NMC_MSTATE_ADR: rdMux[15:0] = {lenCnt, 4'h0, phase, muteStep};
			default:        rdMux       = 32'h0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			avs_readdata <= 32'h0;
		else if (avs_read && avs_waitrequest)
			avs_readdata <= rdMux;
	end

	////////////////////////////////////////////////////////////////////
	// plain control registers, low lane only except jitter control
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dspCtl   <= 8'h00;
			ratioThr <= 8'h00;
			jitCtl   <= 16'h0000;
			muteLen  <= NMC_MUTLEN_RST;
			intEn    <= 8'h00;
			receive_attenuation_reg   <= 3'h0;
			tmgCtl   <= NMC_TMGCTL_RST[1:0];
			devCfg   <= 8'h00;
		end else if (wrStb) begin
			if (avs_byteenable[0]) begin
				case (byteAdr)
					NMC_DSPCTL_ADR: dspCtl          <= avs_writedata[7:0];
					NMC_RATIO_ADR:  ratioThr        <= avs_writedata[7:0];
					NMC_JITCTL_ADR: jitCtl.phaseThr <= avs_writedata[7:0];
					NMC_MUTLEN_ADR: muteLen         <= avs_writedata[7:0];
					NMC_INTMSK_ADR: intEn           <= avs_writedata[7:0] & NMC_INT_MASK;
					NMC_RXATT_ADR:  receive_attenuation_reg          <= avs_writedata[2:0];
					NMC_TMGCTL_ADR: tmgCtl          <= avs_writedata[1:0];
					NMC_DEVCFG_ADR: devCfg          <= avs_writedata[7:0];
					default: ;
				endcase
			end
			if (avs_byteenable[1] && byteAdr == NMC_JITCTL_ADR)
				jitCtl.eventThr <= avs_writedata[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////
	// trigger sources
	assign suppOn = dspCtl[NMC_DSP_SUPP_BIT] && dspCtl[1:0] == NMC_CODEC_NORMAL;
	assign ratioProd = {16'h0000, ratioThr} * {8'h00, errMag};
	assign dspTrig = nsCtl.dspEn && predValid && {8'h00, predMag} < ratioProd;
	assign jitSig = rxEdge && rxPhaseDeg >= jitCtl.phaseThr;
	assign jitTrig = jitSig && !jitFired && !frameStart
		&& (9'(jitCnt) + 9'h1) >= {1'b0, jitCtl.eventThr};
	assign zeroTrig = nibbleValid && adpcmNibble == 4'h0
		&& devCfg[NMC_DEV_ZERO_BIT] && devCfg[5:4] == NMC_MUX_FIRST;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			jitCnt   <= 8'h00;
			jitFired <= 1'b0;
		end else if (frameStart) begin
			jitCnt   <= 8'h00;
			jitFired <= 1'b0;
		end else if (jitSig) begin
			if (jitCnt != 8'hff)
				jitCnt <= jitCnt + 8'h01;
			if (jitTrig)
				jitFired <= 1'b1;
		end
	end

	always_comb begin
		case (nsCtl.trigSel)
			NMC_SRC_DSP: ladderTrig = suppOn && (dspTrig || zeroTrig);
			NMC_SRC_JIT: ladderTrig = suppOn && jitTrig;
			default:     ladderTrig = suppOn && (dspTrig || zeroTrig || jitTrig);
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// noise control: config bits plus sticky status, write one to clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			nsCtl <= 8'h00;
		end else begin
			if (wrStb && avs_byteenable[0] && byteAdr == NMC_NSCTL_ADR) begin
				nsCtl.dspEn   <= avs_writedata[5];
				nsCtl.trigSel <= avs_writedata[3:2];
				nsCtl.muteSeq <= avs_writedata[1:0];
				nsCtl.jitStat <= nsCtl.jitStat && !avs_writedata[7];
				nsCtl.dspStat <= nsCtl.dspStat && !avs_writedata[6];
				nsCtl.zeroStat <= nsCtl.zeroStat && !avs_writedata[4];
			end
			if (jitTrig)
				nsCtl.jitStat <= 1'b1;
			if (dspTrig)
				nsCtl.dspStat <= 1'b1;
			if (zeroTrig)
				nsCtl.zeroStat <= 1'b1;
		end
	end

	// shared interrupt source and link indicators; set wins over clear
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			intStat <= 8'h00;
		end else begin
			if (wrStb && avs_byteenable[0] && byteAdr == NMC_INTCLR_ADR)
				intStat <= intStat & ~avs_writedata[7:0];
			if (dspTrig || jitTrig || zeroTrig)
				intStat[NMC_INT_NOISE_BIT] <= 1'b1;
			if (dChanErr)
				intStat[NMC_INT_DCHAN_BIT] <= 1'b1;
			if (syncErr)
				intStat[NMC_INT_SYNC_BIT] <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(intStat & intEn);
	end

	////////////////////////////////////////////////////////////////////
	// mute length tick divider
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			divCnt   <= 16'h0000;
			muteTick <= 1'b0;
		end else if (divCnt == 16'(FRAME_TICK_CYC - 1)) begin
			divCnt   <= 16'h0000;
			muteTick <= 1'b1;
		end else begin
			divCnt   <= divCnt + 16'h0001;
			muteTick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// mute ladder
	always_comb begin
		case (nsCtl.muteSeq)
			2'h0:    maxStep = NMC_STEP_FULL;
			2'h1:    maxStep = NMC_STEP_FULL;
			2'h2:    maxStep = 3'h3;
			default: maxStep = 3'h2;
		endcase
	end

	always_comb begin
		if (nsCtl.muteSeq == 2'h0)
			next_step = NMC_STEP_FULL;
		else if (muteStep < maxStep)
			next_step = muteStep + 3'h1;
		else
			next_step = muteStep;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			muteStep <= 3'h0;
			lenCnt   <= 8'h00;
			phase    <= NMC_QUIET;
		end else begin
			case (phase)
				NMC_QUIET: begin
					if (ladderTrig) begin
						muteStep <= next_step;
						lenCnt   <= 8'h00;
						phase    <= NMC_MUTING;
					end
				end
				NMC_MUTING: begin
					if (ladderTrig) begin
						muteStep <= next_step;
						lenCnt   <= 8'h00;
					end else if (muteTick) begin
						if (lenCnt >= muteLen) begin
							lenCnt <= 8'h00;
							if (muteStep <= 3'h1)
								phase <= NMC_QUIET;
							if (muteStep != 3'h0)
								muteStep <= muteStep - 3'h1;
						end else begin
							lenCnt <= lenCnt + 8'h01;
						end
					end
				end
				default: phase <= NMC_QUIET;
			endcase
		end
	end

	// software attenuation and automatic ladder: deeper one wins
	assign muteLevel = (receive_attenuation_reg > muteStep) ? receive_attenuation_reg : muteStep;

	nmc_rx_gain u_gain (
		.clock       (clock),
		.rst_n       (rst_n),
		.sampleIn    (rxSample),
		.sampleValid (rxSampleValid),
		.step        (muteLevel),
		.sampleOut   (dacSample),
		.outValid    (dacValid)
	);

	////////////////////////////////////////////////////////////////////
	// receive pll controls
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			timingRecoveryEn <= 1'b1;
			pllSlowForce     <= 1'b0;
			pllMaxStepCyc    <= NMC_FAST_STEP;
			pllFastReq       <= 1'b0;
		end else begin
			timingRecoveryEn <= tmgCtl[NMC_TMG_RECOV_BIT];
			pllSlowForce     <= tmgCtl[NMC_TMG_SLOW_BIT];
			pllMaxStepCyc    <= tmgCtl[NMC_TMG_SLOW_BIT] ? NMC_SLOW_STEP : NMC_FAST_STEP;
			pllFastReq       <= jitTrig && !tmgCtl[NMC_TMG_SLOW_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_trig_gate: assert property (!suppOn |=> muteStep <= $past(muteStep))
		else $error("ladder moved without suppression enabled");
	a_src_jitter: assert property (nsCtl.trigSel == NMC_SRC_JIT && dspTrig && !jitTrig
		|-> !ladderTrig)
		else $error("dsp trigger leaked with jitter source selected");
	a_step_cap: assert property (ladderTrig |=> muteStep <= $past(maxStep)
		|| muteStep == $past(muteStep))
		else $error("mute step beyond sequence maximum");
	a_step_rise: assert property (ladderTrig && nsCtl.muteSeq != 2'h0
		&& muteStep < maxStep |=> muteStep == $past(muteStep) + 3'h1)
		else $error("trigger did not deepen muting by one step");
	a_step_fall: assert property (phase == NMC_MUTING && muteTick && !ladderTrig
		&& lenCnt >= muteLen && muteStep != 3'h0 |=> muteStep == $past(muteStep) - 3'h1)
		else $error("recovery did not remove one step");
	a_cnt_restart: assert property (ladderTrig |=> lenCnt == 8'h00 ##1
		(lenCnt <= 8'h01))
		else $error("mute length counter not restarted");
	a_jit_status: assert property (jitTrig && intEn[NMC_INT_NOISE_BIT]
		|=> nsCtl.jitStat ##1 irq)
		else $error("jitter trigger missed status or interrupt");
	a_dsp_status: assert property (dspTrig |=> nsCtl.dspStat
		&& intStat[NMC_INT_NOISE_BIT])
		else $error("dsp trigger missed status");
	a_zero_gate: assert property (zeroTrig |-> devCfg[NMC_DEV_ZERO_BIT]
		&& devCfg[5:4] == NMC_MUX_FIRST ##1 nsCtl.zeroStat)
		else $error("zero nibble detect outside its mode");
	a_slow_limit: assert property (tmgCtl[NMC_TMG_SLOW_BIT] |=> pllMaxStepCyc == NMC_SLOW_STEP)
		else $error("slow response step limit wrong");
	a_full_zero: assert property (rxSampleValid && muteLevel == NMC_STEP_FULL
		|=> dacSample == 16'sh0000 && dacValid)
		else $error("full mute passed a nonzero sample");

	c_full_mute: cover property (ladderTrig ##1 muteStep == NMC_STEP_FULL);
	c_recover: cover property (phase == NMC_MUTING ##[1:1000] phase == NMC_QUIET);
	c_jit_irq: cover property (jitTrig ##2 irq);
endmodule
`default_nettype wire

/* hdl/nmc_rx_gain.sv */
/*
 * nmc_rx_gain: applies the current mute step to decoded receive samples.
 * Assumes samples arrive as single-cycle valid strobes on the system clock.
 */
`timescale 1ns/1ns
`default_nettype none
module nmc_rx_gain
	import nmc_pkg::*;
(
	input  wire logic              clock,       // system clock
	input  wire logic              rst_n,       // async reset, low
	input  wire logic signed [15:0] sampleIn,   // decoded sample
	input  wire logic              sampleValid, // sample strobe
	input  wire logic [2:0]        step,        // mute step 0..7, full mute from 4
	output logic signed [15:0]     sampleOut,   // attenuated sample
	output logic                   outValid     // output strobe
);
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sampleOut <= 16'sh0000;
		end else if (sampleValid) begin
			if (step >= NMC_STEP_FULL)
				sampleOut <= 16'sh0000;
			else
				sampleOut <= sampleIn >>> step;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			outValid <= 1'b0;
		else
			outValid <= sampleValid;
	end
endmodule
`default_nettype wire

/* pkg/nmc_pkg.sv */
/*
 * nmc_pkg: register map, field positions, reset values and timing counts
 * for the receive noise-mute control block.
 * Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
 */
package nmc_pkg;
	// timing
	localparam int CLK_MHZ            = 100;
	localparam int FRAME_RATE_HZ      = 8000;
	localparam int NMC_FRAME_TICK_CYC = CLK_MHZ * 1000000 / FRAME_RATE_HZ;
	localparam int SLOW_STEP_NS       = 108;
	localparam int BIT_PERIOD_NS      = 13880;
	localparam int SLOW_STEP_CYC      = SLOW_STEP_NS * CLK_MHZ / 1000;
	localparam int BIT_PERIOD_CYC     = BIT_PERIOD_NS * CLK_MHZ / 1000;
	localparam logic [7:0]  NMC_SLOW_STEP = 8'(SLOW_STEP_CYC);
	localparam logic [7:0]  NMC_FAST_STEP = 8'hff;
	localparam logic [10:0] NMC_BIT_CYC   = 11'(BIT_PERIOD_CYC);
	// byte addresses
	localparam logic [7:0] NMC_DSPCTL_ADR = 8'h00;
	localparam logic [7:0] NMC_NSCTL_ADR  = 8'h04;
	localparam logic [7:0] NMC_RATIO_ADR  = 8'h08;
	localparam logic [7:0] NMC_JITCTL_ADR = 8'h0c;
	localparam logic [7:0] NMC_MUTLEN_ADR = 8'h10;
	localparam logic [7:0] NMC_INTSRC_ADR = 8'h14;
	localparam logic [7:0] NMC_INTCLR_ADR = 8'h18;
	localparam logic [7:0] NMC_INTMSK_ADR = 8'h1c;
	localparam logic [7:0] NMC_RXATT_ADR  = 8'h20;
	localparam logic [7:0] NMC_TMGCTL_ADR = 8'h24;
	localparam logic [7:0] NMC_DEVCFG_ADR = 8'h28;
	localparam logic [7:0] NMC_MSTATE_ADR = 8'h2c;
	// field positions
	localparam int NMC_DSP_SUPP_BIT  = 7;
	localparam int NMC_DEV_ZERO_BIT  = 2;
	localparam int NMC_INT_DCHAN_BIT = 0;
	localparam int NMC_INT_SYNC_BIT  = 1;
	localparam int NMC_INT_NOISE_BIT = 5;
	localparam int NMC_TMG_RECOV_BIT = 0;
	localparam int NMC_TMG_SLOW_BIT  = 1;
	localparam logic [1:0] NMC_CODEC_NORMAL = 2'h0;
	localparam logic [1:0] NMC_MUX_FIRST    = 2'h0;
	localparam logic [1:0] NMC_SRC_DSP      = 2'h0;
	localparam logic [1:0] NMC_SRC_JIT      = 2'h1;
	localparam logic [7:0] NMC_NS_W1C_MASK  = 8'hd0;
	localparam logic [7:0] NMC_INT_MASK     = 8'h23;
	// mute ladder steps: 0, -6, -12, -18 dB, full mute
	localparam logic [2:0] NMC_STEP_FULL = 3'h4;
	// reset values
	localparam logic [7:0] NMC_TMGCTL_RST = 8'h01;
	localparam logic [7:0] NMC_MUTLEN_RST = 8'h10;

	typedef struct packed {
		logic       jitStat;
		logic       dspStat;
		logic       dspEn;
		logic       zeroStat;
		logic [1:0] trigSel;
		logic [1:0] muteSeq;
	} nmc_nsctl_t;

	typedef struct packed {
		logic [7:0] eventThr;
		logic [7:0] phaseThr;
	} nmc_jitctl_t;

	typedef enum logic {NMC_QUIET, NMC_MUTING} nmc_phase_t;
endpackage

/* tb/nmc_noise_mute_tb.sv */
/*
 * nmc_noise_mute_tb: register-level bench for the noise-mute block.
 * Assumes a short frame tick so that mute recovery runs in a few hundred cycles.
 */
`timescale 1ns/1ns
`default_nettype none
module nmc_noise_mute_tb
	import nmc_pkg::*;
;
	localparam int TICK = 10;
	logic clock, rst_n, avs_read, avs_write, avs_waitrequest, irq, dacValid;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rdata;
	logic signed [15:0] dacSample;
	logic timingRecoveryEn, pllSlowForce, pllFastReq;
	logic [7:0] pllMaxStepCyc, rxPhaseDeg;
	logic predValid, rxEdge, frameStart, nibbleValid, dChanErr, syncErr, rxSampleValid;
	logic [15:0] predMag, errMag, rxSample;
	logic [3:0] adpcmNibble;
	int n_errors, num_checks, i, m, k;
	int fastCnt = 0;
	nmc_rx_source src (.clock(clock), .predValid(predValid), .predMag(predMag),
		.errMag(errMag), .rxEdge(rxEdge), .rxPhaseDeg(rxPhaseDeg), .frameStart(frameStart),
		.nibbleValid(nibbleValid), .adpcmNibble(adpcmNibble), .dChanErr(dChanErr),
		.syncErr(syncErr), .rxSample(rxSample), .rxSampleValid(rxSampleValid));
	nmc_noise_mute #(.FRAME_TICK_CYC(TICK)) dut (.clock(clock), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.predValid(predValid), .predMag(predMag), .errMag(errMag), .rxEdge(rxEdge),
		.rxPhaseDeg(rxPhaseDeg), .frameStart(frameStart), .nibbleValid(nibbleValid),
		.adpcmNibble(adpcmNibble), .dChanErr(dChanErr), .syncErr(syncErr),
		.rxSample(rxSample), .rxSampleValid(rxSampleValid), .dacSample(dacSample),
		.dacValid(dacValid), .timingRecoveryEn(timingRecoveryEn),
		.pllSlowForce(pllSlowForce), .pllMaxStepCyc(pllMaxStepCyc), .pllFastReq(pllFastReq));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (pllFastReq === 1'b1) fastCnt++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// avalon master: hold the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		avs_write <= wr;
		avs_read <= !wr;
		avs_address <= a[5:2];
		avs_writedata <= d;
		do begin
			@(posedge clock);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 64);
		rdata = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 64) begin
			n_errors++;
			$display("Error bus wait expected 0 seen 1");
			test_done();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, e, rdata);
	endtask
	task automatic stepIs(input logic [2:0] e);
		bus(1'b0, NMC_MSTATE_ADR, 32'h0);
		chk("muteStep", {29'h0, e}, {29'h0, rdata[2:0]});
	endtask
	task automatic trig(input int n);
		repeat (n) src.pred(16'h0001, 16'h0001);
	endtask
	task automatic samp(input logic [15:0] s, input logic [15:0] e);
		src.sample(s);
		#1;
		chk("dacValid", 32'h1, {31'h0, dacValid});
		chk("dacSample", {16'h0, e}, {16'h0, dacSample});
	endtask
	// poll the ladder down to zero, one step at a time
	task automatic recover();
		logic [2:0] prev;
		int j;
		bus(1'b0, NMC_MSTATE_ADR, 32'h0);
		prev = rdata[2:0];
		for (j = 0; j < 400 && prev != 3'h0; j++) begin
			bus(1'b0, NMC_MSTATE_ADR, 32'h0);
			if (rdata[2:0] != prev) chk("step drop", {29'h0, prev - 3'h1}, {29'h0, rdata[2:0]});
			prev = rdata[2:0];
		end
		chk("recovered", 32'h0, {29'h0, prev});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		n_errors = 0;
		num_checks = 0;
		rst_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		repeat (16) @(posedge clock);
		chk("pllMaxStepCyc", 32'h000000ff, {24'h0, pllMaxStepCyc});
		chk("waitrequest irq", 32'h2, {30'h0, avs_waitrequest, irq});
		rst_n <= 1'b1;
		for (i = 0; i < 12; i++)
			rdc("reset value", 8'(4 * i), (i == 4) ? {24'h0, NMC_MUTLEN_RST} :
				(i == 9) ? {24'h0, NMC_TMGCTL_RST} : 32'h0);
		wr(8'h3c, 32'hff);
		rdc("unmapped", 8'h3c, 32'h0);
		wr(NMC_INTSRC_ADR, 32'hff);
		rdc("intsrc ro", NMC_INTSRC_ADR, 32'h0);
		avs_byteenable <= 4'h1;
		wr(NMC_JITCTL_ADR, 32'h7f11);
		avs_byteenable <= 4'h2;
		wr(NMC_JITCTL_ADR, 32'h2233);
		avs_byteenable <= 4'hf;
		rdc("jitctl lanes", NMC_JITCTL_ADR, 32'h2211);
		wr(NMC_RATIO_ADR, 32'h2);
		wr(NMC_MUTLEN_ADR, 32'h3);
		wr(NMC_INTMSK_ADR, 32'h23);
		wr(NMC_DSPCTL_ADR, 32'h80);
		wr(NMC_NSCTL_ADR, 32'h01);
		trig(1);
		rdc("dsp off status", NMC_NSCTL_ADR, 32'h01);
		stepIs(3'h0);
		for (m = 0; m < 4; m++) begin
			wr(NMC_NSCTL_ADR, 32'h20 | m);
			trig(1);
			stepIs((m == 0) ? 3'h4 : 3'h1);
			trig(4);
			stepIs((m == 0) ? 3'h4 : 3'(5 - m));
			samp(16'h0400, (m <= 1) ? 16'h0 : 16'(16'h0400 >> (5 - m)));
			recover();
		end
		rdc("dsp status", NMC_NSCTL_ADR, 32'h63);
		rdc("intsrc noise", NMC_INTSRC_ADR, 32'h20);
		chk("irq", 32'h1, {31'h0, irq});
		wr(NMC_INTCLR_ADR, 32'h20);
		rdc("intsrc clear", NMC_INTSRC_ADR, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		wr(NMC_NSCTL_ADR, 32'h61);
		rdc("status w1c", NMC_NSCTL_ADR, 32'h21);
		src.pred(16'h0004, 16'h0002);
		stepIs(3'h0);
		src.pred(16'h0003, 16'h0002);
		stepIs(3'h1);
		trig(1);
		samp(16'h0400, 16'h0100);
		samp(16'hfc00, 16'hff00);
		bus(1'b0, NMC_MSTATE_ADR, 32'h0);
		for (k = 0; k < 200 && rdata[2:0] != 3'h1; k++) bus(1'b0, NMC_MSTATE_ADR, 32'h0);
		chk("step one", 32'h1, {29'h0, rdata[2:0]});
		trig(1);
		stepIs(3'h2);
		recover();
		wr(NMC_RXATT_ADR, 32'h3);
		samp(16'h0400, 16'h0080);
		wr(NMC_RXATT_ADR, 32'h0);
		wr(NMC_INTCLR_ADR, 32'h23);
		wr(NMC_INTMSK_ADR, 32'h03);
		trig(1);
		rdc("masked src", NMC_INTSRC_ADR, 32'h20);
		chk("irq masked", 32'h0, {31'h0, irq});
		src.link(1'b1, 1'b0);
		rdc("dchan src", NMC_INTSRC_ADR, 32'h21);
		chk("irq dchan", 32'h1, {31'h0, irq});
		src.link(1'b0, 1'b1);
		rdc("sync src", NMC_INTSRC_ADR, 32'h23);
		wr(NMC_INTCLR_ADR, 32'h23);
		wr(NMC_INTMSK_ADR, 32'h23);
		recover();
		wr(NMC_DSPCTL_ADR, 32'h81);
		trig(1);
		stepIs(3'h0);
		wr(NMC_DSPCTL_ADR, 32'h80);
		wr(NMC_INTCLR_ADR, 32'h20);
		wr(NMC_MUTLEN_ADR, 32'h40);
		wr(NMC_NSCTL_ADR, 32'hc5);
		wr(NMC_JITCTL_ADR, 32'h025a);
		src.frame();
		src.edgeEv(8'h59);
		src.edgeEv(8'h5a);
		rdc("jitter one", NMC_NSCTL_ADR, 32'h05);
		src.edgeEv(8'h5a);
		rdc("jitter status", NMC_NSCTL_ADR, 32'h85);
		stepIs(3'h1);
		rdc("jitter int", NMC_INTSRC_ADR, 32'h20);
		chk("fast req", 32'h1, 32'(fastCnt));
		wr(NMC_NSCTL_ADR, 32'h25);
		trig(1);
		stepIs(3'h1);
		wr(NMC_TMGCTL_ADR, 32'h02);
		repeat (2) @(posedge clock);
		chk("tmg outputs", 32'h1, {30'h0, timingRecoveryEn, pllSlowForce});
		chk("slow step", {24'h0, NMC_SLOW_STEP}, {24'h0, pllMaxStepCyc});
		src.frame();
		src.edgeEv(8'h5a);
		src.edgeEv(8'h5a);
		rdc("indicators run", NMC_NSCTL_ADR, 32'he5);
		chk("fast req", 32'h1, 32'(fastCnt));
		wr(NMC_TMGCTL_ADR, 32'h01);
		repeat (2) @(posedge clock);
		chk("fast step", 32'hff, {24'h0, pllMaxStepCyc});
		wr(NMC_NSCTL_ADR, 32'hc1);
		wr(NMC_MUTLEN_ADR, 32'h3);
		recover();
		wr(NMC_DEVCFG_ADR, 32'h14);
		src.nibble(4'h0);
		rdc("zero other mux", NMC_NSCTL_ADR, 32'h01);
		wr(NMC_DEVCFG_ADR, 32'h04);
		src.nibble(4'h5);
		rdc("nonzero nibble", NMC_NSCTL_ADR, 32'h01);
		src.nibble(4'h0);
		rdc("zero status", NMC_NSCTL_ADR, 32'h11);
		stepIs(3'h1);
		wr(NMC_NSCTL_ADR, 32'h09);
		src.frame();
		src.edgeEv(8'h5a);
		src.edgeEv(8'h5a);
		stepIs(3'h2);
		test_done();
	end
endmodule
`default_nettype wire

/* tb/nmc_rx_source.sv */
/*
 * nmc_rx_source: far-side model of the codec receive path and formatter,
 * producing predictor, jitter, nibble, link and sample events.
 * Assumes the bench calls its tasks from one process, one task at a time.
 */
`timescale 1ns/1ns
`default_nettype none
module nmc_rx_source (
	input  wire logic  clock,        // system clock
	output logic        predValid,    // ratio strobe
	output logic [15:0] predMag,      // predicted magnitude
	output logic [15:0] errMag,       // prediction error
	output logic        rxEdge,       // rx transition
	output logic [7:0]  rxPhaseDeg,   // its deviation
	output logic        frameStart,   // frame boundary
	output logic        nibbleValid,  // nibble strobe
	output logic [3:0]  adpcmNibble,  // nibble value
	output logic        dChanErr,     // d channel error
	output logic        syncErr,      // sync error
	output logic [15:0] rxSample,     // decoded sample
	output logic        rxSampleValid // sample strobe
);
	initial begin
		{predValid, predMag, errMag, rxEdge, rxPhaseDeg, frameStart} = '0;
		{nibbleValid, adpcmNibble, dChanErr, syncErr, rxSample, rxSampleValid} = '0;
	end
	////////////////////////////////////////////////////////////////////////
	// each event is one strobe cycle; idle data lines are scrambled
	task automatic pred(input logic [15:0] p, input logic [15:0] e);
		@(posedge clock);
		predValid <= 1'b1;
		predMag <= p;
		errMag <= e;
		@(posedge clock);
		predValid <= 1'b0;
		predMag <= ~p;
		errMag <= ~e;
	endtask
	task automatic edgeEv(input logic [7:0] ph);
		@(posedge clock);
		rxEdge <= 1'b1;
		rxPhaseDeg <= ph;
		@(posedge clock);
		rxEdge <= 1'b0;
		rxPhaseDeg <= ~ph;
	endtask
	task automatic frame();
		@(posedge clock);
		frameStart <= 1'b1;
		@(posedge clock);
		frameStart <= 1'b0;
	endtask
	task automatic nibble(input logic [3:0] n);
		@(posedge clock);
		nibbleValid <= 1'b1;
		adpcmNibble <= n;
		@(posedge clock);
		nibbleValid <= 1'b0;
		adpcmNibble <= ~n;
	endtask
	task automatic link(input logic d, input logic s);
		@(posedge clock);
		dChanErr <= d;
		syncErr <= s;
		@(posedge clock);
		dChanErr <= 1'b0;
		syncErr <= 1'b0;
	endtask
	task automatic sample(input logic [15:0] s);
		@(posedge clock);
		rxSampleValid <= 1'b1;
		rxSample <= s;
		@(posedge clock);
		rxSampleValid <= 1'b0;
		rxSample <= ~s;
	endtask
endmodule
`default_nettype wire
